/* hw/ssp_top.sv */
// Notes on behaviour
// RULE1: Write-disable clears the write-enable latch when it completes.
// RULE2: Host sends write-disable as one byte between chip select low and high.
// RULE3: Latch clears at reset and after disable, status write, program and erases.
// RULE4: Identification read shifts out maker byte then two device bytes, 24 bits.
// RULE5: Identification read is ignored while busy; standby after chip select rises.
// RULE6: Status read works any time and repeats the status byte until deselect.
// RULE7: Host should poll busy before sending a new command during a cycle.
// RULE8: Status bit 0 is busy during program, erase or status write.
// RULE9: Status bit 1 is the latch; program, erase, status write need it set.
// RULE10: Bits 3 and 2 protect areas; chip erase only when both are zero.
// RULE11: Bit 7 with write-protect low gives hardware mode, freezing bits 7, 3, 2.
// RULE12: Status write keeps bits 6, 5, 4, 1, 0; bits 6 to 4 read zero.
// RULE13: Status write executes only with the latch already set.
// RULE14: Status write is code plus one byte, ending on a byte boundary.
// RULE15: Status write cycle starts at deselect, busy throughout, then latch clears.
// RULE16: Bit 7 zero, or write-protect high, allows status writes to bits 7, 3, 2.
// RULE17: Bit 7 set with write-protect low rejects status writes despite the latch.
// RULE18: Hardware mode holds whatever order bit 7 and write-protect low arrive in.
// RULE19: Hardware mode ends only when write-protect goes high; here reset also ends it by clearing bit 7.
// RULE20: Write-enable sets the latch needed by program, erase and status write.
// RULE21: Input sampled on rising serial clock, output shifted on falling edge.
// RULE22: Commands without output are rejected unless deselect is on a byte boundary.
// RULE23: Block-protect bits map to a protected region checked by program and erase.
`timescale 1ns/1ns
`include "ssp_cfg.svh"
module ssp_top #(
    parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value.
    parameter logic [15:0] DEVICE_ID = 16'h5A3C, // Arbitrary value.
    parameter logic [23:0] WRITE_SR_CYCLES = `SSP_T_WRITE_SR,
    parameter logic [23:0] PROG_CYCLES = `SSP_T_PROG,
    parameter logic [23:0] SECT_CYCLES = `SSP_T_SECT,
    parameter logic [23:0] BLK_CYCLES = `SSP_T_BLK,
    parameter logic [23:0] CE_CYCLES = `SSP_T_CE
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Serial link pins.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // Protection state.
    output logic hardware_protection_mode
);
    logic [3:0] pin_s;
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic wp_n_s;
    logic sclk_prev_reg;
    logic cs_n_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic active;
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] new_byte;
    logic byte_done;
    ssp_pkg::ssp_state_t state_reg;
    ssp_pkg::ssp_state_t state_next;
    logic [7:0] cmd_reg;
    logic [23:0] addr_reg;
    logic [7:0] wdata_reg;
    logic busy_flag;
    logic write_enable_latch;
    logic status_write_disable;
    logic block_protect_hi;
    logic block_protect_lo;
    logic [7:0] status_byte;
    logic hw_prot;
    logic on_boundary;
    logic commit;
    logic protected_hit;
    ssp_pkg::ssp_op_t op_reg;
    ssp_pkg::ssp_op_t op_next;
    logic [23:0] op_cycles;
    logic [2:0] nv_pending_reg;
    logic [4:0] id_idx;
    logic [23:0] id_word;
    logic so_reg;
    logic so_oe_reg;
    logic hw_prot_reg;

    ssp_tmr_if #(.W(24)) tmr_bus ();

    ssp_sync #(.WIDTH(4)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({cs_n, sclk, si, wp_n}),
        .q(pin_s)
    );

    assign cs_n_s = pin_s[3];
    assign sclk_s = pin_s[2];
    assign si_s = pin_s[1];
    assign wp_n_s = pin_s[0];

    ssp_timer #(.W(24)) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .t(tmr_bus)
    );

    // Edge detection on the synchronised pins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_reg <= 1'b1;
            cs_n_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
            cs_n_prev_reg <= cs_n_s;
        end
    end

    assign active = !cs_n_s;
    assign sclk_rise = active && sclk_s && !sclk_prev_reg; // RULE21
    assign sclk_fall = active && !sclk_s && sclk_prev_reg; // RULE21
    assign cs_rise = cs_n_s && !cs_n_prev_reg;
    assign new_byte = {shift_reg, si_s};
    assign byte_done = sclk_rise && (bit_cnt_reg == 3'd7);
    assign on_boundary = (bit_cnt_reg == 3'd0); // RULE22

    // Serial input shifter with bit and byte counters.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 3'd0;
            shift_reg <= 7'h00;
        end else if (!active) begin
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 3'd0;
        end else if (sclk_rise) begin
            shift_reg <= new_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            if (byte_done && byte_cnt_reg != 3'd7) begin
                byte_cnt_reg <= byte_cnt_reg + 3'd1;
            end
        end
    end

    // Command decode; only status read is taken while a cycle runs.
    always_comb begin
        state_next = state_reg;
        if (!active) begin
            state_next = ssp_pkg::ST_IDLE;
        end else if (state_reg == ssp_pkg::ST_IDLE) begin
            state_next = ssp_pkg::ST_CMD;
        end else if (byte_done && byte_cnt_reg == 3'd0) begin
            case (new_byte)
                `SSP_CMD_READ_SR: state_next = ssp_pkg::ST_SR_OUT; // RULE6
                `SSP_CMD_READ_ID: begin
                    state_next = busy_flag ? ssp_pkg::ST_IGNORE : ssp_pkg::ST_ID_OUT; // RULE5
                end
                `SSP_CMD_WRITE_EN, `SSP_CMD_WRITE_DIS, `SSP_CMD_CE_A, `SSP_CMD_CE_B: begin
                    state_next = busy_flag ? ssp_pkg::ST_IGNORE : ssp_pkg::ST_CMD;
                end
                `SSP_CMD_WRITE_SR, `SSP_CMD_PROG, `SSP_CMD_SECT_ERASE,
                `SSP_CMD_BLK_ERASE_A, `SSP_CMD_BLK_ERASE_B: begin
                    state_next = busy_flag ? ssp_pkg::ST_IGNORE : ssp_pkg::ST_DATA;
                end
                default: state_next = ssp_pkg::ST_IGNORE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ssp_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Command byte, address and status data capture.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= 8'h00;
            addr_reg <= 24'h00_0000;
            wdata_reg <= 8'h00;
        end else if (byte_done) begin
            if (byte_cnt_reg == 3'd0) begin
                cmd_reg <= new_byte;
            end else if (state_reg == ssp_pkg::ST_DATA) begin
                if (byte_cnt_reg == 3'd1) begin
                    wdata_reg <= new_byte;
                end
                if (byte_cnt_reg <= 3'd3) begin
                    addr_reg <= {addr_reg[15:0], new_byte};
                end
            end
        end
    end

    // Protected region: 01 top quarter, 10 top half, 11 whole array.
    always_comb begin
        case ({block_protect_hi, block_protect_lo})
            2'b01: protected_hit = (addr_reg[15:14] == 2'b11); // RULE23
            2'b10: protected_hit = addr_reg[15]; // RULE23
            2'b11: protected_hit = 1'b1; // RULE10
            default: protected_hit = 1'b0;
        endcase
    end

    assign hw_prot = status_write_disable && !wp_n_s; // RULE11 RULE18 RULE19
    // A frame that was ignored while busy stays ignored even if the cycle ends before deselect.
    assign commit = cs_rise && on_boundary && !busy_flag && (state_reg != ssp_pkg::ST_IGNORE); // RULE22 RULE5

    // Which self-timed operation a completed command starts.
    always_comb begin
        op_next = ssp_pkg::OP_NONE;
        op_cycles = WRITE_SR_CYCLES;
        if (commit && write_enable_latch) begin // RULE9 RULE20
            case (cmd_reg)
                `SSP_CMD_WRITE_SR: begin
                    if (byte_cnt_reg == `SSP_LEN_WRITE_SR && !hw_prot) begin // RULE13 RULE14 RULE16 RULE17
                        op_next = ssp_pkg::OP_WRITE_SR;
                    end
                end
                `SSP_CMD_PROG: begin
                    if (byte_cnt_reg >= `SSP_LEN_PROG && !protected_hit) begin
                        op_next = ssp_pkg::OP_PROG;
                        op_cycles = PROG_CYCLES;
                    end
                end
                `SSP_CMD_SECT_ERASE: begin
                    if (byte_cnt_reg == `SSP_LEN_ADDR && !protected_hit) begin
                        op_next = ssp_pkg::OP_SECT;
                        op_cycles = SECT_CYCLES;
                    end
                end
                `SSP_CMD_BLK_ERASE_A, `SSP_CMD_BLK_ERASE_B: begin
                    if (byte_cnt_reg == `SSP_LEN_ADDR && !protected_hit) begin
                        op_next = ssp_pkg::OP_BLK;
                        op_cycles = BLK_CYCLES;
                    end
                end
                `SSP_CMD_CE_A, `SSP_CMD_CE_B: begin
                    if (byte_cnt_reg == `SSP_LEN_ONE && !block_protect_hi && !block_protect_lo) begin // RULE10
                        op_next = ssp_pkg::OP_CE;
                        op_cycles = CE_CYCLES;
                    end
                end
                default: op_next = ssp_pkg::OP_NONE;
            endcase
        end
    end

    assign tmr_bus.start = (op_next != ssp_pkg::OP_NONE); // RULE15
    assign tmr_bus.load = op_cycles;

    // Busy flag and the running operation.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_flag <= 1'b0;
            op_reg <= ssp_pkg::OP_NONE;
            nv_pending_reg <= `SSP_NV_RESET;
        end else if (tmr_bus.start) begin
            busy_flag <= 1'b1; // RULE8 RULE15
            op_reg <= op_next;
            nv_pending_reg <= {wdata_reg[`SSP_SR_SWD], wdata_reg[`SSP_SR_BP_HI], wdata_reg[`SSP_SR_BP_LO]};
        end else if (tmr_bus.done) begin
            busy_flag <= 1'b0; // RULE8 RULE15
            op_reg <= ssp_pkg::OP_NONE;
        end
    end

    // Non-volatile bits change only at reset and when a status write completes.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {status_write_disable, block_protect_hi, block_protect_lo} <= `SSP_NV_RESET;
        end else if (tmr_bus.done && op_reg == ssp_pkg::OP_WRITE_SR) begin
            {status_write_disable, block_protect_hi, block_protect_lo} <= nv_pending_reg; // RULE10 RULE12
        end
    end

    // Write-enable latch.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch <= 1'b0; // RULE3
        end else if (tmr_bus.done) begin
            write_enable_latch <= 1'b0; // RULE3 RULE15
        end else if (commit && cmd_reg == `SSP_CMD_WRITE_DIS && byte_cnt_reg == `SSP_LEN_ONE) begin
            write_enable_latch <= 1'b0; // RULE1
        end else if (commit && cmd_reg == `SSP_CMD_WRITE_EN && byte_cnt_reg == `SSP_LEN_ONE) begin
            write_enable_latch <= 1'b1; // RULE20
        end
    end

    // Bits 6 to 4 are constant zero.
    assign status_byte = {status_write_disable, 3'b000, block_protect_hi, block_protect_lo,
                          write_enable_latch, busy_flag}; // RULE12

    assign id_word = {MAKER_ID, DEVICE_ID};
    assign id_idx = {2'(byte_cnt_reg - 3'd1), bit_cnt_reg};

    // Serial output, changed on falling serial clock edges.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (!active) begin
            so_oe_reg <= 1'b0;
        end else if (sclk_fall) begin
            if (state_reg == ssp_pkg::ST_SR_OUT) begin
                so_reg <= status_byte[3'd7 - bit_cnt_reg]; // RULE6
                so_oe_reg <= 1'b1;
            end else if (state_reg == ssp_pkg::ST_ID_OUT && byte_cnt_reg <= 3'd3) begin
                so_reg <= id_word[5'd23 - id_idx]; // RULE4
                so_oe_reg <= 1'b1;
            end else begin
                so_oe_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hw_prot_reg <= 1'b0;
        end else begin
            hw_prot_reg <= hw_prot;
        end
    end

    assign so = so_reg;
    assign so_oe = so_oe_reg;
    assign hardware_protection_mode = hw_prot_reg;
endmodule

/* pkg/ssp_cfg.svh */
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Command codes taken on the serial input.
`define SSP_CMD_WRITE_EN 8'h06
`define SSP_CMD_WRITE_DIS 8'h04
`define SSP_CMD_READ_ID 8'h9F
`define SSP_CMD_READ_SR 8'h05
`define SSP_CMD_WRITE_SR 8'h01
`define SSP_CMD_PROG 8'h02
`define SSP_CMD_SECT_ERASE 8'h20
`define SSP_CMD_BLK_ERASE_A 8'h52
`define SSP_CMD_BLK_ERASE_B 8'hD8
`define SSP_CMD_CE_A 8'h60
`define SSP_CMD_CE_B 8'hC7

// Status byte field positions.
`define SSP_SR_BUSY 0
`define SSP_SR_LATCH 1
`define SSP_SR_BP_LO 2
`define SSP_SR_BP_HI 3
`define SSP_SR_SWD 7

// Reset value of the non-volatile bits.
`define SSP_NV_RESET 3'b000

// Byte counts of complete commands.
`define SSP_LEN_WRITE_SR 3'd2
`define SSP_LEN_ADDR 3'd4
`define SSP_LEN_PROG 3'd5
`define SSP_LEN_ONE 3'd1

// Default self-timed cycle lengths in clock cycles.
`define SSP_T_WRITE_SR 24'd1000
`define SSP_T_PROG 24'd2000
`define SSP_T_SECT 24'd4000
`define SSP_T_BLK 24'd6000
`define SSP_T_CE 24'd8000

`endif

/* pkg/ssp_pkg.sv */
package ssp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA,
        ST_SR_OUT,
        ST_ID_OUT,
        ST_IGNORE
    } ssp_state_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WRITE_SR,
        OP_PROG,
        OP_SECT,
        OP_BLK,
        OP_CE
    } ssp_op_t;

endpackage

/* pkg/ssp_tmr_if.sv */
`timescale 1ns/1ns
interface ssp_tmr_if #(parameter int W = 24);
    logic start;
    logic [W-1:0] load;
    logic done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

/* hw/ssp_sync.sv */
`timescale 1ns/1ns
module ssp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Asynchronous level in, synchronised level out.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // Two flip-flops; the first is read only by the second.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            q <= '1;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* hw/ssp_timer.sv */
`timescale 1ns/1ns
module ssp_timer #(
    parameter int W = 24
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Start, load and done.
    ssp_tmr_if.tmr t
);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    logic done_reg;

    assign t.done = done_reg;

    // Counts the loaded number of cycles and pulses done once at the end.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (t.start) begin
                cnt_reg <= t.load;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg <= W'(1)) begin
                    run_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - W'(1);
                end
            end
        end
    end
endmodule

/* dv/ssp_top_monitor.sv */
`timescale 1ns/1ns
module ssp_top_monitor (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Serial link pins.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    // Protection state.
    input wire logic hardware_protection_mode
);
    logic [3:0] rise_cnt_reg;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Counts serial clock rises within one frame.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rise_cnt_reg <= 4'h0;
        end else if (cs_n) begin
            rise_cnt_reg <= 4'h0;
        end else if ($rose(sclk) && rise_cnt_reg != 4'hf) begin
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
        end
    end

    property p_hwprot_off_wp_high;
        wp_n [*5] |-> !hardware_protection_mode;
    endproperty
    a_hwprot_off_wp_high: assert property (p_hwprot_off_wp_high)
        else $error("protection mode held with write-protect high");

    property p_hwprot_rise_wp_low;
        $rose(hardware_protection_mode) |-> !wp_n;
    endproperty
    a_hwprot_rise_wp_low: assert property (p_hwprot_rise_wp_low)
        else $error("protection mode entered with write-protect high");

    property p_hwprot_hold;
        (!wp_n) [*4] ##0 hardware_protection_mode |=> hardware_protection_mode;
    endproperty
    a_hwprot_hold: assert property (p_hwprot_hold)
        else $error("protection mode left while write-protect low");

    property p_oe_idle;
        cs_n [*5] |-> !so_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("output driven while deselected");

    property p_oe_rise;
        $rose(so_oe) |-> !cs_n && rise_cnt_reg >= 4'h8;
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("output enabled before a full command byte");

    property p_oe_stop;
        $rose(cs_n) |-> ##[1:5] !so_oe;
    endproperty
    a_oe_stop: assert property (p_oe_stop)
        else $error("output still enabled after deselect");

    property p_so_stable;
        so_oe && $rose(sclk) |=> $stable(so) [*3];
    endproperty
    a_so_stable: assert property (p_so_stable)
        else $error("serial output moved after a rising clock");

    property p_so_change_low;
        so_oe && $past(so_oe) && $changed(so) |-> !sclk;
    endproperty
    a_so_change_low: assert property (p_so_change_low)
        else $error("serial output changed while serial clock high");

    c_out: cover property ($rose(so_oe));
    c_hwprot_on: cover property ($rose(hardware_protection_mode));
    c_hwprot_off: cover property ($fell(hardware_protection_mode));
endmodule

/* dv/ssp_host_model.sv */
`timescale 1ns/1ns
module ssp_host_model (
    // Clock.
    input wire logic clock,
    // Serial link pins.
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic oe_seen;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end

    // Sends bits n-1 down to 0 of tx in mode 0 and gathers output at each rising edge.
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0000_0000;
        oe_seen = 1'b0;
        @(negedge clock);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            repeat (4) @(negedge clock);
            sclk = 1'b1;
            rx = {rx[30:0], so};
            oe_seen = oe_seen | so_oe;
            repeat (4) @(negedge clock);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        si = ~si;
        repeat (6) @(negedge clock);
    endtask
endmodule

/* dv/tb_serial_flash_status_protect.sv */
`timescale 1ns/1ns
`include "ssp_cfg.svh"
module tb_serial_flash_status_protect;
    localparam logic [7:0] MKR = 8'h5b; // Arbitrary value.
    localparam logic [15:0] DEV = 16'hc371; // Arbitrary value.
    localparam logic [23:0] CYC = 24'h00_01f4;
    logic clock, rst_n, cs_n, sclk, si, wp_n, so, so_oe, hw_prot;
    logic [31:0] got, r, seed;
    logic [7:0] d;
    logic [31:0] exp_q[$];
    int n_mismatch, compares, cycles;
    event got_ev;

    ssp_top #(.MAKER_ID(MKR), .DEVICE_ID(DEV), .WRITE_SR_CYCLES(CYC), .PROG_CYCLES(CYC), .SECT_CYCLES(CYC),
        .BLK_CYCLES(CYC), .CE_CYCLES(CYC)) dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .hardware_protection_mode(hw_prot));
    ssp_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));

    initial clock = 1'b0;
    always #50 clock = ~clock;

    task check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task test_done;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Notes an expected value and hands the observed one to the watcher.
    task note(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got = g;
        -> got_ev;
    endtask

    always @(got_ev) check(got, exp_q.pop_front());

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction

    task cmd(input logic [7:0] c);
        host.frame({24'h00_0000, c}, 8, r);
    endtask

    task write_sr(input logic [7:0] v, input int extra);
        host.frame({16'h0000, `SSP_CMD_WRITE_SR, v} << extra, 16 + extra, r);
    endtask

    // Reads two status bytes in one frame; both must match.
    task read_sr(input logic [7:0] e);
        host.frame({8'h00, `SSP_CMD_READ_SR, 16'h0000}, 24, r);
        note({16'h0000, e, e}, {16'h0000, r[15:0]});
    endtask

    task wait_idle;
        for (int k = 0; k < 20; k++) begin
            host.frame({16'h0000, `SSP_CMD_READ_SR, 8'h00}, 16, r);
            if (r[0] === 1'b0) break;
        end
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        seed = 32'h0000_f01f;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        read_sr(8'h00);
        cmd(`SSP_CMD_WRITE_EN);
        read_sr(8'h02);
        cmd(`SSP_CMD_WRITE_DIS);
        read_sr(8'h00);
        host.frame({`SSP_CMD_READ_ID, 24'h00_0000}, 32, r);
        note({8'h00, MKR, DEV}, {8'h00, r[23:0]});
        write_sr(8'h8c, 0);
        read_sr(8'h00);
        seed = lfsr(seed);
        d = seed[7:0] | 8'h84;
        cmd(`SSP_CMD_WRITE_EN);
        write_sr(d, 1);
        read_sr(8'h02);
        write_sr(d, 0);
        read_sr(8'h03);
        host.frame({`SSP_CMD_READ_ID, 24'h00_0000}, 32, r);
        note(32'h0000_0000, {31'h0000_0000, host.oe_seen});
        wait_idle();
        read_sr(d & 8'h8c);
        cmd(`SSP_CMD_WRITE_EN);
        cmd(`SSP_CMD_CE_B);
        // The top quarter is protected whether the upper protect bit came up 0 or 1.
        host.frame({`SSP_CMD_SECT_ERASE, 24'h00_ffff}, 32, r);
        read_sr((d & 8'h8c) | 8'h02);
        wp_n = 1'b0;
        repeat (5) @(negedge clock);
        note(32'h0000_0001, {31'h0000_0000, hw_prot});
        write_sr(8'h00, 0);
        read_sr((d & 8'h8c) | 8'h02);
        wp_n = 1'b1;
        repeat (5) @(negedge clock);
        note(32'h0000_0000, {31'h0000_0000, hw_prot});
        write_sr(8'h00, 0);
        read_sr((d & 8'h8c) | 8'h03);
        wait_idle();
        read_sr(8'h00);
        cmd(`SSP_CMD_WRITE_EN);
        host.frame({`SSP_CMD_SECT_ERASE, 24'h00_ffff}, 32, r);
        read_sr(8'h03);
        wait_idle();
        read_sr(8'h00);
        cmd(`SSP_CMD_WRITE_EN);
        cmd(`SSP_CMD_CE_A);
        read_sr(8'h03);
        wait_idle();
        read_sr(8'h00);
        cmd(`SSP_CMD_WRITE_EN);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        read_sr(8'h00);
        wp_n = 1'b0;
        cmd(`SSP_CMD_WRITE_EN);
        write_sr(8'h80, 0);
        wait_idle();
        repeat (5) @(negedge clock);
        note(32'h0000_0001, {31'h0000_0000, hw_prot});
        wp_n = 1'b1;
        repeat (5) @(negedge clock);
        test_done();
    end
endmodule

bind ssp_top ssp_top_monitor mon (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .hardware_protection_mode(hardware_protection_mode));
